// ---- dcs_master_model.sv ----
// fieldbus master stand-in: one register access per go pulse
// assumes the bank answers with a one-cycle ack
`timescale 1ns/1ps
`default_nettype none
module dcs_master_model (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire logic go, // start one access
  input wire logic go_wr, // access is a write
  input wire logic [15:0] go_addr, // register number
  input wire logic [15:0] go_wdata, // value to write
  input wire logic ack, // answer from the bank
  output logic req, // request pulse
  output logic wr, // write select
  output logic [15:0] addr, // register number
  output logic [15:0] wdata, // write value
  output logic busy // access outstanding
);
  // ****************************************
  // master side
  // ****************************************
  function automatic logic [15:0] lim(logic [15:0] a, logic [15:0] v);
    if (a == dcs_pkg::REG_SETPOINT && $signed(v) > dcs_pkg::SETPOINT_MAX) return 16'h1388;
    if (a == dcs_pkg::REG_SETPOINT && $signed(v) < dcs_pkg::SETPOINT_MIN) return 16'hEC78;
    if (a == dcs_pkg::REG_RAMP && v > 16'hEA60) return 16'hEA60;
    return v;
  endfunction
  always_ff @(posedge clk) begin
    if (rst) begin
      req <= 1'b0;
      wr <= 1'b0;
      busy <= 1'b0;
      addr <= 16'h0000;
      wdata <= 16'h0000;
    end else if (go && !busy) begin
      req <= 1'b1;
      wr <= go_wr;
      addr <= go_addr;
      wdata <= lim(go_addr, go_wdata);
      busy <= 1'b1;
    end else begin
      req <= 1'b0;
      if (busy && ack) begin
        busy <= 1'b0;
        addr <= ~addr;
        wdata <= ~wdata;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dcs_pkg.sv ----
// constants and carrier types for the drive control/status register bank
// assumes one 200 MHz clock and a decoded single-register fieldbus access port
package dcs_pkg;

  // ****************************************
  // register indices (holding register numbers)
  // ****************************************
  localparam logic [15:0] REG_COMMAND = 16'h0001;
  localparam logic [15:0] REG_SETPOINT = 16'h0002;
  localparam logic [15:0] REG_RAMP = 16'h0004;
  localparam logic [15:0] REG_STATUS = 16'h0006;
  localparam logic [15:0] REG_OUT_FREQ = 16'h0007;
  localparam logic [15:0] REG_OUT_CURR = 16'h0008;
  localparam logic [15:0] REG_OUT_POWER = 16'h000A;
  localparam logic [15:0] REG_DIG_IN = 16'h000B;
  localparam logic [15:0] REG_RATING_ID = 16'h000C;
  localparam logic [15:0] REG_POWER_RATING = 16'h000D;
  localparam logic [15:0] REG_SUPPLY_RATING = 16'h000E;
  localparam logic [15:0] REG_IO_VERSION = 16'h000F;
  localparam logic [15:0] REG_MC_VERSION = 16'h0010;
  localparam logic [15:0] REG_TYPE_CODE = 16'h0011;
  localparam logic [15:0] REG_ANALOG_ONE = 16'h0014;
  localparam logic [15:0] REG_ANALOG_TWO = 16'h0015;
  localparam logic [15:0] REG_PRE_RAMP = 16'h0016;
  localparam logic [15:0] REG_DC_BUS = 16'h0017;
  localparam logic [15:0] REG_TEMPERATURE = 16'h0018;
  localparam logic [15:0] REG_PARAM_SELECT = 16'h002C;
  localparam logic [15:0] REG_PARAM_VALUE = 16'h002D;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CMD_RUN_BIT = 0;
  localparam int CMD_FAST_STOP_BIT = 1;
  localparam int CMD_FAULT_RESET_BIT = 2;
  localparam int CMD_COAST_BIT = 3;

  // ****************************************
  // limits and parameter table
  // ****************************************
  localparam logic signed [15:0] SETPOINT_MAX = 16'sh1388;
  localparam logic signed [15:0] SETPOINT_MIN = -16'sh1388;
  localparam logic [15:0] RAMP_OVERRIDE_ON = 16'h0001;
  localparam int NUM_PARAMS = 6;
  localparam logic [15:0] RESET_ZERO = 16'h0000;

  // parameter table entry: number, range, run lock, reset value
  typedef struct packed {
    logic [15:0] number;
    logic [15:0] min_value;
    logic [15:0] max_value;
    logic run_locked;
    logic [15:0] reset_value;
  } dcs_param_desc_t;

  // slots: max freq, min freq, accel, decel, second decel, ramp override select
  localparam int P_MAX_FREQ = 0;
  localparam int P_MIN_FREQ = 1;
  localparam int P_ACCEL = 2;
  localparam int P_DECEL = 3;
  localparam int P_DECEL2 = 4;
  localparam int P_RAMP_SEL = 5;

  localparam dcs_param_desc_t PARAM_TABLE [NUM_PARAMS] = '{
    '{16'h0065, 16'h0000, 16'h1388, 1'b1, 16'h01F4},
    '{16'h0066, 16'h0000, 16'h1388, 1'b0, 16'h0000},
    '{16'h0067, 16'h0000, 16'hEA60, 1'b0, 16'h01F4},
    '{16'h0068, 16'h0000, 16'hEA60, 1'b0, 16'h01F4},
    '{16'h00E1, 16'h0000, 16'hEA60, 1'b0, 16'h0000},
    '{16'h01FC, 16'h0000, 16'h0001, 1'b1, 16'h0000}
  };

  // ****************************************
  // carriers
  // ****************************************
  typedef enum logic [1:0] {
    DCS_MODE_STOP = 2'b00,
    DCS_MODE_RUN = 2'b01,
    DCS_MODE_FAST_STOP = 2'b10,
    DCS_MODE_COAST = 2'b11
  } dcs_mode_t;

  // live measurements from the drive core
  typedef struct packed {
    logic [15:0] out_freq;
    logic [15:0] out_current;
    logic [15:0] out_power;
    logic [15:0] digital_inputs;
    logic [15:0] analog_one;
    logic [15:0] analog_two;
    logic [15:0] pre_ramp_ref;
    logic [15:0] dc_bus;
    logic [15:0] temperature;
    logic [7:0] error_code;
    logic enabled;
    logic tripped;
    logic hand_mode;
    logic safe_torque_inhibit;
    logic maintenance_due;
    logic standby;
  } dcs_monitor_t;

  // commands towards the drive core
  typedef struct packed {
    dcs_mode_t mode;
    logic fault_reset;
    logic reverse;
    logic [15:0] freq_magnitude;
    logic [15:0] accel_time;
    logic [15:0] decel_time;
  } dcs_drive_cmd_t;

  // whole register state
  typedef struct packed {
    logic [15:0] command;
    logic [15:0] setpoint;
    logic [15:0] ramp;
    logic [15:0] param_select;
    logic [NUM_PARAMS-1:0][15:0] params;
    logic [15:0] rdata;
    logic ack;
    logic err;
    dcs_drive_cmd_t drive;
  } dcs_state_t;

endpackage

// ---- dcs_regs.sv ----
// holding-register bank of the drive: command, setpoint, status, monitors, parameters
// assumes the fieldbus framer presents one decoded register access per request pulse
//
// Function
// RULE1: command bit 0 one runs the drive, zero stops it.
// RULE2: command bit 1 stops using the second deceleration ramp time.
// RULE3: command bit 2 one requests a fault reset.
// RULE4: master returns bit 2 to zero after fault clears.
// RULE5: command bit 3 one makes the motor coast freely.
// RULE6: coast beats fast stop beats run.
// RULE7: setpoint is signed 16-bit in tenths of hertz.
// RULE8: negative setpoint commands reverse rotation.
// RULE9: setpoint limited to +-5000 and to min/max frequency settings.
// RULE10: ramp register sets both ramps when override select equals one.
// RULE11: master writes ramp time 0 to 60000 hundredths of seconds.
// RULE12: status high byte holds last error code.
// RULE13: status low byte flags enabled, tripped, hand, inhibit, maintenance, standby.
// RULE14: output frequency and current reported with one decimal place.
// RULE15: output power reported with two decimals in kilowatts.
// RULE16: digital input register maps input n to bit n-1.
// RULE17: analog registers return scaled level, 4096 full scale.
// RULE18: version registers hold versions with two implied decimals.
// RULE19: master writes parameter number to register 44 first.
// RULE20: reading register 45 returns selected parameter value.
// RULE21: parameter changes only on register 45 writes.
// RULE22: error on missing parameter, out of range, or run-locked while enabled.
// RULE23: rejected parameter write leaves value unchanged.
`timescale 1ns/1ps
`default_nettype none

module dcs_regs #(
  parameter logic [15:0] RATING_ID = 16'h0001,     // arbitrary value
  parameter logic [15:0] POWER_RATING = 16'h004B,  // two decimals
  parameter logic [15:0] SUPPLY_RATING = 16'h0190, // nominal volts
  parameter logic [15:0] IO_VERSION = 16'h0064,    // two decimals
  parameter logic [15:0] MC_VERSION = 16'h0064,    // two decimals
  parameter logic [15:0] TYPE_CODE = 16'h0001      // arbitrary value
) (
  input wire logic clk,                         // 200 MHz clock
  input wire logic rst,                         // synchronous reset, active high
  input wire logic ce,                          // clock enable, freezes state when low
  input wire logic req,                         // one-cycle access request
  input wire logic wr,                          // 1 write, 0 read
  input wire logic [15:0] addr,                 // holding register number
  input wire logic [15:0] wdata,                // write value
  input wire dcs_pkg::dcs_monitor_t mon,        // live drive measurements
  output logic ack,                             // one-cycle answer pulse
  output logic err,                             // answer is an error response
  output logic [15:0] rdata,                    // read data, valid with ack
  output var dcs_pkg::dcs_drive_cmd_t drive     // resolved drive commands
);

  // ****************************************
  // state
  // ****************************************
  dcs_pkg::dcs_state_t st;
  dcs_pkg::dcs_state_t next_st;

  logic [dcs_pkg::NUM_PARAMS-1:0] hit;
  logic param_found;
  logic [15:0] sel_value;
  logic [15:0] sel_min;
  logic [15:0] sel_max;
  logic sel_locked;
  logic [15:0] status_word;

  // ****************************************
  // parameter lookup
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < dcs_pkg::NUM_PARAMS; g++) begin : g_hit
      assign hit[g] = (st.param_select == dcs_pkg::PARAM_TABLE[g].number);
    end
  endgenerate

  always_comb begin
    param_found = 1'b0;
    sel_value = dcs_pkg::RESET_ZERO;
    sel_min = dcs_pkg::RESET_ZERO;
    sel_max = dcs_pkg::RESET_ZERO;
    sel_locked = 1'b0;
    for (int i = 0; i < dcs_pkg::NUM_PARAMS; i++) begin
      if (hit[i]) begin
        param_found = 1'b1;
        sel_value = st.params[i];                                   // [RULE20]
        sel_min = dcs_pkg::PARAM_TABLE[i].min_value;
        sel_max = dcs_pkg::PARAM_TABLE[i].max_value;
        sel_locked = dcs_pkg::PARAM_TABLE[i].run_locked;
      end
    end
  end

  // status: error code high, flags low, bits 6 and 7 zero
  assign status_word = {mon.error_code, 2'b00, mon.standby, mon.maintenance_due,
                        mon.safe_torque_inhibit, mon.hand_mode, mon.tripped,
                        mon.enabled};                               // [RULE12] [RULE13]

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic signed [15:0] sp;
    logic [15:0] mag;
    logic [15:0] fmin;
    logic [15:0] fmax;
    logic use_override;
    next_st = st;
    sp = 16'sh0000;
    mag = dcs_pkg::RESET_ZERO;
    fmin = dcs_pkg::RESET_ZERO;
    fmax = dcs_pkg::RESET_ZERO;
    use_override = 1'b0;
    next_st.ack = 1'b0;
    next_st.err = 1'b0;

    if (req) begin
      next_st.ack = 1'b1;
      next_st.rdata = dcs_pkg::RESET_ZERO;
      if (wr) begin
        case (addr)
          dcs_pkg::REG_COMMAND: next_st.command = wdata;
          dcs_pkg::REG_SETPOINT: next_st.setpoint = wdata;
          dcs_pkg::REG_RAMP: next_st.ramp = wdata;
          dcs_pkg::REG_PARAM_SELECT: next_st.param_select = wdata;  // [RULE19] [RULE21]
          dcs_pkg::REG_PARAM_VALUE: begin
            if (!param_found || wdata < sel_min || wdata > sel_max ||
                (sel_locked && mon.enabled)) begin
              next_st.err = 1'b1;                                   // [RULE22] [RULE23]
            end else begin
              for (int i = 0; i < dcs_pkg::NUM_PARAMS; i++) begin
                if (hit[i]) begin
                  next_st.params[i] = wdata;                        // [RULE21]
                end
              end
            end
          end
          default: next_st.err = 1'b1;
        endcase
        next_st.rdata = wdata;
      end else begin
        case (addr)
          dcs_pkg::REG_COMMAND: next_st.rdata = st.command;
          dcs_pkg::REG_SETPOINT: next_st.rdata = st.setpoint;
          dcs_pkg::REG_RAMP: next_st.rdata = st.ramp;
          dcs_pkg::REG_STATUS: next_st.rdata = status_word;
          dcs_pkg::REG_OUT_FREQ: next_st.rdata = mon.out_freq;       // [RULE14]
          dcs_pkg::REG_OUT_CURR: next_st.rdata = mon.out_current;    // [RULE14]
          dcs_pkg::REG_OUT_POWER: next_st.rdata = mon.out_power;     // [RULE15]
          dcs_pkg::REG_DIG_IN: next_st.rdata = mon.digital_inputs;   // [RULE16]
          dcs_pkg::REG_RATING_ID: next_st.rdata = RATING_ID;
          dcs_pkg::REG_POWER_RATING: next_st.rdata = POWER_RATING;
          dcs_pkg::REG_SUPPLY_RATING: next_st.rdata = SUPPLY_RATING;
          dcs_pkg::REG_IO_VERSION: next_st.rdata = IO_VERSION;       // [RULE18]
          dcs_pkg::REG_MC_VERSION: next_st.rdata = MC_VERSION;       // [RULE18]
          dcs_pkg::REG_TYPE_CODE: next_st.rdata = TYPE_CODE;
          dcs_pkg::REG_ANALOG_ONE: next_st.rdata = mon.analog_one;   // [RULE17]
          dcs_pkg::REG_ANALOG_TWO: next_st.rdata = mon.analog_two;   // [RULE17]
          dcs_pkg::REG_PRE_RAMP: next_st.rdata = mon.pre_ramp_ref;
          dcs_pkg::REG_DC_BUS: next_st.rdata = mon.dc_bus;
          dcs_pkg::REG_TEMPERATURE: next_st.rdata = mon.temperature;
          dcs_pkg::REG_PARAM_SELECT: next_st.rdata = st.param_select;
          dcs_pkg::REG_PARAM_VALUE: begin
            next_st.rdata = sel_value;                              // [RULE20]
            next_st.err = !param_found;
          end
          default: next_st.err = 1'b1;
        endcase
      end
    end

    // command resolution from the stored word
    if (st.command[dcs_pkg::CMD_COAST_BIT]) begin
      next_st.drive.mode = dcs_pkg::DCS_MODE_COAST;                 // [RULE5] [RULE6]
    end else if (st.command[dcs_pkg::CMD_FAST_STOP_BIT]) begin
      next_st.drive.mode = dcs_pkg::DCS_MODE_FAST_STOP;             // [RULE2] [RULE6]
    end else if (st.command[dcs_pkg::CMD_RUN_BIT]) begin
      next_st.drive.mode = dcs_pkg::DCS_MODE_RUN;                   // [RULE1] [RULE6]
    end else begin
      next_st.drive.mode = dcs_pkg::DCS_MODE_STOP;                  // [RULE1]
    end
    next_st.drive.fault_reset = st.command[dcs_pkg::CMD_FAULT_RESET_BIT]; // [RULE3]

    // signed setpoint, clamp to +-5000 then to the frequency limits
    sp = $signed(st.setpoint);                                      // [RULE7]
    if (sp > dcs_pkg::SETPOINT_MAX) begin
      sp = dcs_pkg::SETPOINT_MAX;                                   // [RULE9]
    end else if (sp < dcs_pkg::SETPOINT_MIN) begin
      sp = dcs_pkg::SETPOINT_MIN;                                   // [RULE9]
    end
    next_st.drive.reverse = sp[15];                                 // [RULE8]
    mag = sp[15] ? 16'(-sp) : 16'(sp);
    fmin = st.params[dcs_pkg::P_MIN_FREQ];
    fmax = st.params[dcs_pkg::P_MAX_FREQ];
    if (mag > fmax) begin
      mag = fmax;                                                   // [RULE9]
    end
    if (mag < fmin) begin
      mag = fmin;                                                   // [RULE9]
    end
    next_st.drive.freq_magnitude = mag;

    // ramp times: override register or separate settings; fast stop uses second ramp
    use_override = (st.params[dcs_pkg::P_RAMP_SEL] == dcs_pkg::RAMP_OVERRIDE_ON);
    next_st.drive.accel_time = use_override ? st.ramp : st.params[dcs_pkg::P_ACCEL]; // [RULE10]
    if (next_st.drive.mode == dcs_pkg::DCS_MODE_FAST_STOP) begin
      next_st.drive.decel_time = st.params[dcs_pkg::P_DECEL2];      // [RULE2]
    end else begin
      next_st.drive.decel_time = use_override ? st.ramp : st.params[dcs_pkg::P_DECEL]; // [RULE10]
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      for (int i = 0; i < dcs_pkg::NUM_PARAMS; i++) begin
        st.params[i] <= dcs_pkg::PARAM_TABLE[i].reset_value;
      end
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign ack = st.ack;
  assign err = st.err;
  assign rdata = st.rdata;
  assign drive = st.drive;

endmodule

`default_nettype wire

// ---- dcs_regs_chk.sv ----
// concurrent checks on the drive register bank ports
// assumes a bind onto dcs_regs from the bench top file
`timescale 1ns/1ps
`default_nettype none
module dcs_regs_chk (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire logic ce, // clock enable
  input wire logic req, // request pulse
  input wire logic wr, // write select
  input wire logic [15:0] addr, // register number
  input wire logic [15:0] wdata, // write value
  input wire dcs_pkg::dcs_monitor_t mon, // live values
  input wire logic ack, // answer pulse
  input wire logic err, // error answer
  input wire logic [15:0] rdata, // read data
  input wire dcs_pkg::dcs_drive_cmd_t drive // drive commands
);
  // ****************************************
  // properties
  // ****************************************
  wire logic [3:0] cmd_low = wdata[3:0];
  wire logic [15:0] status_now = {mon.error_code, 2'b00, mon.standby, mon.maintenance_due,
    mon.safe_torque_inhibit, mon.hand_mode, mon.tripped, mon.enabled};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence taken(logic w, logic [15:0] a);
    req && ce && wr == w && addr == a;
  endsequence
  property cmd_mode(logic [3:0] m, logic [3:0] p, dcs_pkg::dcs_mode_t md);
    taken(1'b1, dcs_pkg::REG_COMMAND) ##0 ((cmd_low & m) == p) |=> ack ##1 drive.mode == md;
  endproperty
  AST_ANSWER: assert property (req && ce ##1 ce |-> ack ##1 !ack) else $error("answer not one pulse");
  AST_COAST: assert property (cmd_mode(4'h8, 4'h8, dcs_pkg::DCS_MODE_COAST))
    else $error("coast not applied");
  AST_FAST: assert property (cmd_mode(4'hA, 4'h2, dcs_pkg::DCS_MODE_FAST_STOP))
    else $error("fast stop not applied");
  AST_RUN: assert property (cmd_mode(4'hB, 4'h1, dcs_pkg::DCS_MODE_RUN))
    else $error("run not applied");
  AST_STOP: assert property (cmd_mode(4'hB, 4'h0, dcs_pkg::DCS_MODE_STOP))
    else $error("stop not applied");
  AST_FAULT_RESET: assert property (taken(1'b1, dcs_pkg::REG_COMMAND) |=> ##1
    drive.fault_reset == $past(cmd_low[2], 2)) else $error("fault reset wrong");
  AST_REVERSE: assert property (taken(1'b1, dcs_pkg::REG_SETPOINT) |=> ##1
    drive.reverse == $past(wdata[15], 2)) else $error("direction wrong");
  AST_STATUS: assert property (taken(1'b0, dcs_pkg::REG_STATUS) |=>
    ack && !err && rdata == $past(status_now)) else $error("status word wrong");
  AST_FREQ: assert property (taken(1'b0, dcs_pkg::REG_OUT_FREQ) |=>
    rdata == $past(mon.out_freq)) else $error("output frequency wrong");
  AST_SELECT_ONLY: assert property (taken(1'b1, dcs_pkg::REG_PARAM_SELECT) |=>
    ##1 $stable(drive)) else $error("select write changed drive");
endmodule
`default_nettype wire

// ---- test_drive_control_status_regs.sv ----
// self-checking bench for the drive register bank
// assumes dcs_pkg, dcs_regs, dcs_master_model and dcs_regs_chk are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_drive_control_status_regs;
  localparam logic [15:0] IDV [6] = '{16'h00A5, 16'h0096, 16'h0190, 16'h00C8, 16'h00D2,
    16'h005A}; // arbitrary identity values
  localparam logic [15:0] RA [16] = '{dcs_pkg::REG_STATUS, dcs_pkg::REG_OUT_FREQ,
    dcs_pkg::REG_OUT_CURR, dcs_pkg::REG_OUT_POWER, dcs_pkg::REG_DIG_IN, dcs_pkg::REG_ANALOG_ONE,
    dcs_pkg::REG_ANALOG_TWO, dcs_pkg::REG_PRE_RAMP, dcs_pkg::REG_DC_BUS,
    dcs_pkg::REG_TEMPERATURE, dcs_pkg::REG_RATING_ID, dcs_pkg::REG_POWER_RATING,
    dcs_pkg::REG_SUPPLY_RATING, dcs_pkg::REG_IO_VERSION, dcs_pkg::REG_MC_VERSION,
    dcs_pkg::REG_TYPE_CODE};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic ce = 1'b1;
  logic go_wr = 1'b0;
  logic [15:0] go_addr = 16'h0000;
  logic [15:0] go_wdata = 16'h0000;
  logic req, wr, ack, err, busy, er;
  logic [15:0] addr, wdata, rdata, rd, d2, sp, rp;
  logic [159:0] r;
  logic [31:0] seed = 32'd41069;
  dcs_pkg::dcs_monitor_t mon = '0;
  dcs_pkg::dcs_drive_cmd_t drive;
  int num_errors = 0;
  int total_checks = 0;
  dcs_master_model u_master (.clk(clk), .rst(rst), .go(go), .go_wr(go_wr), .go_addr(go_addr),
    .go_wdata(go_wdata), .ack(ack), .req(req), .wr(wr), .addr(addr), .wdata(wdata), .busy(busy));
  dcs_regs #(.RATING_ID(IDV[0]), .POWER_RATING(IDV[1]), .SUPPLY_RATING(IDV[2]),
    .IO_VERSION(IDV[3]), .MC_VERSION(IDV[4]), .TYPE_CODE(IDV[5])) DUT (.clk(clk), .rst(rst),
    .ce(ce), .req(req), .wr(wr), .addr(addr), .wdata(wdata), .mon(mon), .ack(ack), .err(err),
    .rdata(rdata), .drive(drive));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic dcs_pkg::dcs_mode_t mode_of(logic [3:0] c);
    if (c[3]) return dcs_pkg::DCS_MODE_COAST;
    if (c[1]) return dcs_pkg::DCS_MODE_FAST_STOP;
    return c[0] ? dcs_pkg::DCS_MODE_RUN : dcs_pkg::DCS_MODE_STOP;
  endfunction
  function automatic logic [15:0] mag_of(logic [15:0] v, logic [15:0] mn, logic [15:0] mx);
    logic [15:0] m;
    m = v[15] ? -v : v;
    return m > mx ? mx : (m < mn ? mn : m);
  endfunction
  function automatic logic [15:0] mon_exp(int k);
    case (k)
      0: return {mon.error_code, 2'b00, mon.standby, mon.maintenance_due,
        mon.safe_torque_inhibit, mon.hand_mode, mon.tripped, mon.enabled};
      1: return mon.out_freq;
      2: return mon.out_current;
      3: return mon.out_power;
      4: return mon.digital_inputs;
      5: return mon.analog_one;
      6: return mon.analog_two;
      7: return mon.pre_ramp_ref;
      8: return mon.dc_bus;
      9: return mon.temperature;
      default: return IDV[k-10];
    endcase
  endfunction
  task automatic finish_test();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(logic w, logic [15:0] a, logic [15:0] d);
    int i;
    @(posedge clk);
    go <= 1'b1;
    go_wr <= w;
    go_addr <= a;
    go_wdata <= d;
    @(posedge clk);
    go <= 1'b0;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      #1;
      if (ack === 1'b1) break;
    end
    rd = rdata;
    er = err;
    if (i == 8) begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic wparam(logic [15:0] n, logic [15:0] v, logic e);
    bus(1'b1, dcs_pkg::REG_PARAM_SELECT, n);
    bus(1'b1, dcs_pkg::REG_PARAM_VALUE, v);
    chk("param_err", 16'(e), 16'(er));
  endtask
  task automatic rparam(logic [15:0] n, logic [15:0] v);
    bus(1'b1, dcs_pkg::REG_PARAM_SELECT, n);
    bus(1'b0, dcs_pkg::REG_PARAM_VALUE, 16'h0000);
    chk("param", v, rd);
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int p = 0; p < dcs_pkg::NUM_PARAMS; p++) begin
      rparam(dcs_pkg::PARAM_TABLE[p].number, dcs_pkg::PARAM_TABLE[p].reset_value);
    end
    d2 = 16'(rnd() % 32'd60001);
    wparam(16'h00E1, d2, 1'b0);
    wparam(16'h0066, 16'h0064, 1'b0);
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, dcs_pkg::REG_COMMAND, 16'(c));
      @(posedge clk);
      #1;
      chk("mode", 16'(mode_of(4'(c))), 16'(drive.mode));
      chk("fault_reset", 16'(c[2]), 16'(drive.fault_reset));
      chk("decel", (!c[3] && c[1]) ? d2 : 16'h01F4, drive.decel_time);
    end
    bus(1'b1, dcs_pkg::REG_COMMAND, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      sp = (i == 0) ? 16'hFFFF : (i == 1) ? 16'hFF16 : (i == 2) ? 16'h01F4
        : 16'(rnd() % 32'd10001 - 32'd5000);
      bus(1'b1, dcs_pkg::REG_SETPOINT, sp);
      @(posedge clk);
      #1;
      chk("reverse", 16'(sp[15]), 16'(drive.reverse));
      chk("speed", mag_of(sp, 16'h0064, 16'h01F4), drive.freq_magnitude);
    end
    rp = 16'(rnd() % 32'd60001);
    bus(1'b1, dcs_pkg::REG_RAMP, rp);
    @(posedge clk);
    #1;
    chk("accel", 16'h01F4, drive.accel_time);
    wparam(16'h01FC, 16'h0001, 1'b0);
    @(posedge clk);
    #1;
    chk("accel", rp, drive.accel_time);
    chk("decel", rp, drive.decel_time);
    // clock enable low for the edge after the write lands: answer and drive freeze
    fork
      bus(1'b1, dcs_pkg::REG_RAMP, d2);
      begin
        repeat (3) @(posedge clk);
        ce <= 1'b0;
        @(posedge clk);
        ce <= 1'b1;
      end
    join
    #1;
    chk("ack_frozen", 16'h0001, 16'(ack));
    chk("accel_frozen", rp, drive.accel_time);
    @(posedge clk);
    #1;
    chk("accel", d2, drive.accel_time);
    wparam(16'h03E7, 16'h0001, 1'b1);
    wparam(16'h0065, 16'h1389, 1'b1);
    mon.enabled <= 1'b1;
    wparam(16'h0065, 16'h012C, 1'b1);
    rparam(16'h0065, 16'h01F4);
    wparam(16'h0067, 16'h1234, 1'b0);
    rparam(16'h0067, 16'h1234);
    rparam(16'h0065, 16'h01F4);
    bus(1'b0, 16'h0003, 16'h0000);
    chk("unmapped_err", 16'h0001, 16'(er));
    for (int i = 0; i < 4; i++) begin
      r = {rnd(), rnd(), rnd(), rnd(), rnd()};
      @(posedge clk);
      mon <= r[157:0];
      for (int k = 0; k < 16; k++) begin
        bus(1'b0, RA[k], 16'h0000);
        chk("monitor", mon_exp(k), rd);
      end
    end
    finish_test();
  end
endmodule
bind dcs_regs dcs_regs_chk u_chk (.clk(clk), .rst(rst), .ce(ce), .req(req), .wr(wr),
  .addr(addr), .wdata(wdata), .mon(mon), .ack(ack), .err(err), .rdata(rdata), .drive(drive));
`default_nettype wire
